// file: hdl/ppcs_defs.svh
`ifndef PPCS_DEFS_SVH
`define PPCS_DEFS_SVH

// Byte addresses of the two registers
`define PPCS_CTRL_ADDR      12'h000
`define PPCS_STAT_ADDR      12'h004

// Control register field positions
`define PPCS_C_LEDOFF       15
`define PPCS_C_TXDIS        14
`define PPCS_C_ANRST        13
`define PPCS_C_PWRDN        12
`define PPCS_C_XDIS         11
`define PPCS_C_XFORCE       10
`define PPCS_C_ANEN         7
`define PPCS_C_SPEED        6
`define PPCS_C_DUPLEX       5
`define PPCS_C_PAUSE        4
`define PPCS_C_ADV_LO       0
`define PPCS_C_ADV_HI       4

// Status register field positions
`define PPCS_S_XALG         15
`define PPCS_S_POLREV       13
`define PPCS_S_RXFC         12
`define PPCS_S_TXFC         11
`define PPCS_S_SPEED        10
`define PPCS_S_DUPLEX       9
`define PPCS_S_MDIX         7
`define PPCS_S_ANDONE       6
`define PPCS_S_LINK         5

// Reset values and control register write mask
`define PPCS_CTRL_RST       16'h009f
`define PPCS_XALG_RST       1'h1
`define PPCS_CTRL_WMASK     16'hfcff

`endif

// file: hdl/ppcs_pkg.sv
`default_nettype none
package ppcs_pkg;
   // Bus access decode result
   typedef enum logic [1:0]
   {
      PPCS_NONE = 2'h0,
      PPCS_CTRL = 2'h1,
      PPCS_STAT = 2'h3
   } ppcs_sel_type;
endpackage
`default_nettype wire

// file: hdl/port_phy_control_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "ppcs_defs.svh"

module port_phy_control_status_regs
(
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        phyPolarityRev,
   input  wire logic        phyRxFlowActive,
   input  wire logic        phyTxFlowActive,
   input  wire logic        phyLinkSpeed100,
   input  wire logic        phyLinkFull,
   input  wire logic        phyMdiStatus,
   input  wire logic        phyAnDone,
   input  wire logic        phyLinkGood,
   input  wire logic        phyAnFailed,
   input  wire logic [4:0]  phyPartnerAbility,
   input  wire logic        phyLedIn0,
   input  wire logic        phyLedIn1,
   input  wire logic        phyLedIn2,
   input  wire logic        phyLedIn3,
   output logic             port_led_out0,
   output logic             port_led_out1,
   output logic             port_led_out2,
   output logic             port_led_out3,
   output logic             phyTxDisable,
   output logic             phyAnRestart,
   output logic             phyPowerDown,
   output logic             phyAutoXoverOff,
   output logic             phyForceXover,
   output logic             phyAnEnable,
   output logic             phyUse100,
   output logic             phyUseFull,
   output logic      [4:0]  phyAdvertise,
   output logic             crossover_algorithm_select
);

   logic [15:0]             ctrl_reg;
   logic                    xalg_reg;
   logic                    anRestart_reg;
   ppcs_pkg::ppcs_sel_type  sel_reg;
   logic                    wr_reg;
   logic [15:0]             status;
   logic                    addrPhase;

   // Address decoding to a register select
   function automatic ppcs_pkg::ppcs_sel_type decode(input logic [11:0] a);
      if (a == `PPCS_CTRL_ADDR)
         decode = ppcs_pkg::PPCS_CTRL;
      else if (a == `PPCS_STAT_ADDR)
         decode = ppcs_pkg::PPCS_STAT;
      else
         decode = ppcs_pkg::PPCS_NONE;
   endfunction

   assign addrPhase = hsel & hready & htrans[1];

   // Zero wait state slave, always OKAY
   assign hreadyout = 1'h1;
   assign hresp     = 1'h0;

   // Capture the address phase for the following data phase
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sel_reg <= ppcs_pkg::PPCS_NONE;
         wr_reg  <= 1'h0;
      end
      else
      begin
         sel_reg <= addrPhase ? decode(haddr) : ppcs_pkg::PPCS_NONE;
         wr_reg  <= addrPhase & hwrite;
      end
   end

   // Control register, reserved bits 9:8 stay zero
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         ctrl_reg <= `PPCS_CTRL_RST;
      else if (wr_reg && sel_reg == ppcs_pkg::PPCS_CTRL)
      begin
         ctrl_reg <= hwdata[15:0] & `PPCS_CTRL_WMASK;
         ctrl_reg[`PPCS_C_ANRST] <= 1'h0;
      end
   end

   // Restart is a one-cycle pulse per written one
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         anRestart_reg <= 1'h0;
      else
         anRestart_reg <= wr_reg && sel_reg == ppcs_pkg::PPCS_CTRL
                          && hwdata[`PPCS_C_ANRST];
   end

   // Writable crossover algorithm bit of the status register
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         xalg_reg <= `PPCS_XALG_RST;
      else if (wr_reg && sel_reg == ppcs_pkg::PPCS_STAT)
         xalg_reg <= hwdata[`PPCS_S_XALG];
   end

   // Live status image; other bits ignore writes
   always_comb
   begin
      status = 16'h0000;
      status[`PPCS_S_XALG]   = xalg_reg;
      status[`PPCS_S_POLREV] = phyPolarityRev;
      status[`PPCS_S_RXFC]   = phyRxFlowActive;
      status[`PPCS_S_TXFC]   = phyTxFlowActive;
      status[`PPCS_S_SPEED]  = phyLinkSpeed100;
      status[`PPCS_S_DUPLEX] = phyLinkFull;
      status[`PPCS_S_MDIX]   = phyMdiStatus;
      status[`PPCS_S_ANDONE] = phyAnDone;
      status[`PPCS_S_LINK]   = phyLinkGood;
      status[4:0]            = phyPartnerAbility;
   end

   // Read data mux in the data phase
   always_comb
   begin
      if (sel_reg == ppcs_pkg::PPCS_CTRL)
         hrdata = {16'h0000, ctrl_reg};
      else if (sel_reg == ppcs_pkg::PPCS_STAT)
         hrdata = {16'h0000, status};
      else
         hrdata = 32'h00000000;
   end

   // LEDs high (off) when blanked
   assign port_led_out0 = ctrl_reg[`PPCS_C_LEDOFF] | phyLedIn0;
   assign port_led_out1 = ctrl_reg[`PPCS_C_LEDOFF] | phyLedIn1;
   assign port_led_out2 = ctrl_reg[`PPCS_C_LEDOFF] | phyLedIn2;
   assign port_led_out3 = ctrl_reg[`PPCS_C_LEDOFF] | phyLedIn3;

   // PHY controls
   assign phyTxDisable    = ctrl_reg[`PPCS_C_TXDIS];
   assign phyAnRestart    = anRestart_reg;
   assign phyPowerDown    = ctrl_reg[`PPCS_C_PWRDN];
   assign phyAutoXoverOff = ctrl_reg[`PPCS_C_XDIS];
   assign phyForceXover   = ctrl_reg[`PPCS_C_XFORCE];
   assign phyAnEnable     = ctrl_reg[`PPCS_C_ANEN];
   assign crossover_algorithm_select = xalg_reg;

   // Forced speed when negotiation is off; forced duplex when off or failed
   assign phyUse100  = ctrl_reg[`PPCS_C_ANEN] ? phyLinkSpeed100
                       : ctrl_reg[`PPCS_C_SPEED];
   assign phyUseFull = (ctrl_reg[`PPCS_C_ANEN] && !phyAnFailed)
                       ? phyLinkFull : ctrl_reg[`PPCS_C_DUPLEX];

   // Advertisement: pause, 100F, 100H, 10F, 10H
   genvar i;
   generate
      for (i = `PPCS_C_ADV_LO; i <= `PPCS_C_ADV_HI; i++)
      begin : gAdv
         assign phyAdvertise[i] = ctrl_reg[i];
      end
   endgenerate

endmodule
`default_nettype wire

// file: verif/ppcs_phy_model.sv
`timescale 1ns/1ps
`default_nettype none
module ppcs_phy_model
(
   input wire logic [17:0] rnd,
   output logic phyPolarityRev, phyRxFlowActive, phyTxFlowActive,
   output logic phyLinkSpeed100, phyLinkFull, phyMdiStatus, phyAnDone,
   output logic phyLinkGood, phyAnFailed, phyLedIn0, phyLedIn1, phyLedIn2,
   output logic phyLedIn3,
   output logic [4:0] phyPartnerAbility
);
   // Line state and partner abilities, one draw at a time
   assign {phyPolarityRev, phyRxFlowActive, phyTxFlowActive, phyLinkSpeed100,
      phyLinkFull, phyMdiStatus, phyAnDone, phyLinkGood, phyAnFailed,
      phyLedIn0, phyLedIn1, phyLedIn2, phyLedIn3, phyPartnerAbility} = rnd;
endmodule
`default_nettype wire

// file: verif/ppcs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ppcs_checker
(
   input wire logic sys_clk, sys_rst, hsel, hwrite, hready, phyAnRestart,
   input wire logic phyPowerDown, phyAnEnable, phyUse100, phyUseFull,
   input wire logic phyLinkSpeed100, phyLinkFull, phyAnFailed, phyLedIn0,
   input wire logic port_led_out0, port_led_out1, port_led_out2,
   input wire logic port_led_out3,
   input wire logic [1:0] htrans,
   input wire logic [11:0] haddr,
   input wire logic [31:0] hrdata
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // Accepted address phases
   wire logic take = hsel && hready && htrans[1];
   wire logic ctlWr = take && hwrite && haddr == 12'h000;
   sequence statRd;
      take && !hwrite && haddr == 12'h004;
   endsequence
   a_led_blank_all: assert property (!phyLedIn0 && port_led_out0 |->
      port_led_out1 && port_led_out2 && port_led_out3) else $error("led");
   a_restart_one_shot: assert property (phyAnRestart |->
      $past(ctlWr, 2) ##1 !phyAnRestart) else $error("restart");
   a_pwrdn_by_write: assert property ($changed(phyPowerDown) |->
      $past(ctlWr, 2)) else $error("power down");
   a_speed_follows: assert property (phyAnEnable |->
      phyUse100 == phyLinkSpeed100) else $error("speed");
   a_forced_speed: assert property (!phyAnEnable && $changed(phyUse100)
      |-> $past(ctlWr, 2)) else $error("forced speed");
   a_duplex_follows: assert property (phyAnEnable && !phyAnFailed |->
      phyUseFull == phyLinkFull) else $error("duplex");
   a_status_reserved: assert property (statRd |=>
      hrdata[31:16] == 16'h0 && !hrdata[14] && !hrdata[8]) else $error("rsv");
   a_unmapped_zero: assert property (take && !hwrite && haddr[11:3] != 9'h0
      |=> hrdata == 32'h0) else $error("unmapped");
endmodule
bind port_phy_control_status_regs ppcs_checker i_ppcs_checker (.*);
`default_nettype wire

// file: verif/port_phy_control_status_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module port_phy_control_status_regs_tb_top;
   logic sys_clk = 1'h0, sys_rst = 1'h1, hsel = 1'h0, hwrite = 1'h0;
   logic hready, hreadyout, hresp, phyPolarityRev, phyRxFlowActive;
   logic phyTxFlowActive, phyLinkSpeed100, phyLinkFull, phyMdiStatus;
   logic phyAnDone, phyLinkGood, phyAnFailed, phyLedIn0, phyLedIn1;
   logic phyLedIn2, phyLedIn3, port_led_out0, port_led_out1, port_led_out2;
   logic port_led_out3, phyTxDisable, phyAnRestart, phyPowerDown;
   logic phyAutoXoverOff, phyForceXover, phyAnEnable, phyUse100, phyUseFull;
   logic crossover_algorithm_select;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [11:0] haddr = 12'h0;
   logic [4:0] phyPartnerAbility, phyAdvertise;
   logic [15:0] v;
   logic [17:0] rnd = 18'h0;
   logic [31:0] hwdata = 32'h0, hrdata, q;
   int failures = 0, checks = 0, pulses = 0, n;
   assign hready = hreadyout;
   port_phy_control_status_regs i_port_phy_control_status_regs (.*);
   ppcs_phy_model i_ppcs_phy_model (.*);
   // Clock and restart pulse count
   always #12.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (phyAnRestart === 1'h1) pulses++;
   task automatic chk(input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One single AHB transfer, address then data phase
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge sys_clk); while (hready !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge sys_clk); while (hready !== 1'h1);
      q = hrdata;
   endtask
   function automatic logic [31:0] stat(input logic x);
      return {16'h0, x, 1'h0, rnd[17:13], 1'h0, rnd[12:10], rnd[4:0]};
   endfunction
   function automatic logic [15:0] ctl(input logic [15:0] c);
      return {rnd[8:5] | {4{c[15]}}, c[14], c[12:10], c[7],
         c[7] ? rnd[14] : c[6], c[7] && !rnd[9] ? rnd[13] : c[5], c[4:0]};
   endfunction
   task results;
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Reset values, then random control and status traffic
   initial
   begin
      void'($urandom(32'h1f0e));
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'h0;
      xfer(1'h0, 12'h000, 32'h0);
      chk(q, 32'h009f);
      xfer(1'h0, 12'h004, 32'h0);
      chk(q, stat(1'h1));
      $display("reset test done");
      for (int i = 0; i < 24; i++)
      begin
         v = i == 0 ? 16'hffff : i == 1 ? 16'h0 : 16'($urandom);
         rnd <= 18'($urandom);
         n = pulses;
         xfer(1'h1, 12'h000, {16'h0, v});
         repeat (3) @(posedge sys_clk);
         chk(32'(pulses - n), {31'h0, v[13]});
         chk({port_led_out0, port_led_out1, port_led_out2, port_led_out3,
            phyTxDisable, phyPowerDown, phyAutoXoverOff, phyForceXover,
            phyAnEnable, phyUse100, phyUseFull, phyAdvertise},
            ctl(v));
         xfer(1'h0, 12'h000, 32'h0);
         chk(q, {16'h0, v & 16'hdcff});
         xfer(1'h1, 12'h004, {16'h0, v});
         @(posedge sys_clk);
         chk(crossover_algorithm_select, v[15]);
         chk({hreadyout, hresp}, 32'h2);
         xfer(1'h0, 12'h004, 32'h0);
         chk(q, stat(v[15]));
         xfer(1'h0, {10'($urandom_range(1023, 2)), 2'h0}, 32'h0);
         chk(q, 32'h0);
      end
      $display("random test done");
      results();
   end
   // Cut a hung run short
   initial
   begin
      #50us;
      failures++;
      results();
   end
endmodule
`default_nettype wire
